// File: dv/drc_drive_model.sv
// Purpose: Drive engine model feeding sector bytes
// Assumes: One read at a time, started by startRead
// Notes: Marks alternate so the skip filter sees both kinds
`timescale 1ns/1ps
module drc_drive_model
    import drc_pkg::*;
#(parameter int NSEC = 4)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Block side
    input wire logic drvReady,
    input wire logic startRead,
    input wire drc_cmd_t cmdOut,
    output drc_sec_t secIn,
    output drc_end_t endIn
);
    int idx;  // Bytes offered so far
    logic act;  // Read under way
    // Offer bytes, then end; data keep changing while invalid
    always_ff @(posedge ref_clk) begin
        endIn <= '0;
        if (sys_rst || startRead) begin
            idx <= 0;
            act <= startRead;
            secIn <= '0;
        end else if (act && (drvReady || !secIn.valid)) begin
            secIn <= {idx < NSEC, 8'hA0 + 8'(idx), idx[0]};
            idx <= idx + 1;
            // End comes only while drvReady is high, as the last byte is taken; that byte still waits at the host unless the skip filter drops it
            if (idx >= NSEC && drvReady) begin
                act <= 1'b0;
                endIn <= {1'b1, 5'h0, cmdOut.headSelectBit, cmdOut.driveSelectHigh,
                    cmdOut.driveSelectLow, 16'h0, cmdOut.cylinder, cmdOut.head,
                    cmdOut.record + 8'(NSEC), cmdOut.sizeCode};
            end
        end
    end
endmodule : drc_drive_model

// File: dv/drc_read_cmd_assertions.sv
// Purpose: Port checks for the sector read command block
// Assumes: One clock, synchronous reset
// Notes: Bound to every drc_read_cmd
`timescale 1ns/1ps
module drc_read_cmd_checker
    import drc_pkg::*;
(
    // Clock, reset and APB answer
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Drive engine and decoder
    input wire drc_sec_t secIn,
    input wire drc_end_t endIn,
    input wire logic drvReady,
    input wire logic startRead,
    input wire drc_cmd_t cmdOut,
    input wire logic otherOpValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Byte taken, and whether the skip filter drops it
    wire logic take = secIn.valid && drvReady;
    wire logic drop = cmdOut.skipMismatchedMarkFlag && (secIn.deletedMark != cmdOut.deletedRead);
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_take; take && !drop |=> !drvReady; endproperty
    a_take: assert property (p_take) else $error("ready kept after a byte");
    property p_skip; take && drop |=> drvReady; endproperty
    a_skip: assert property (p_skip) else $error("dropped byte was held");
    property p_start; startRead |=> !startRead && !otherOpValid; endproperty
    a_start: assert property (p_start) else $error("start not a pulse");
    property p_other; otherOpValid |-> !startRead ##1 !otherOpValid; endproperty
    a_other: assert property (p_other) else $error("foreign opcode started a read");
    property p_end; endIn.valid |-> ##2 !drvReady [*4]; endproperty
    a_end: assert property (p_end) else $error("bytes taken after the end");
    c_start: cover property (startRead);
    c_other: cover property (otherOpValid);
    c_drop: cover property (take && drop);
endmodule : drc_read_cmd_checker
bind drc_read_cmd drc_read_cmd_checker drc_read_cmd_checker_inst (.ref_clk, .sys_rst,
    .psel, .penable, .pready, .pslverr, .prdata, .secIn, .endIn, .drvReady,
    .startRead, .cmdOut, .otherOpValid);

// File: dv/drc_read_cmd_test.sv
// Purpose: Self-checking bench for the sector read command block
// Assumes: Drive model answers every read
// Notes: Expected bytes come from a queue model
`timescale 1ns/1ps
module drc_read_cmd_test;
    import drc_pkg::*;
    localparam int NSEC = 4;  // Sector bytes per read
    localparam int LIM = 50;  // Bound of every wait
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, errv, drvReady, startRead, otherOpValid, irq;
    logic [7:0] otherOp, op;
    logic [7:0] ops [4] = '{8'h06, 8'hE6, 8'h4C, 8'hAC};  // Every flag and both reads
    drc_sec_t secIn;
    drc_end_t endIn;
    drc_cmd_t cmdOut;
    logic [15:0] seed = 16'h51D6;  // Random source
    int fail_count = 0, n_checks = 0;
    initial forever #20 ref_clk = ~ref_clk;
    drc_read_cmd drc_read_cmd_inst (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .secIn, .endIn, .drvReady, .startRead,
        .cmdOut, .otherOpValid, .otherOp, .irq);
    drc_drive_model #(.NSEC(NSEC)) drc_drive_model_inst (.ref_clk, .sys_rst, .drvReady,
        .startRead, .cmdOut, .secIn, .endIn);
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bound(input int k);
        if (k >= LIM) begin
            fail_count++;
            stop_test();
        end
    endtask : bound
    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < LIM);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        bound(k);
    endtask : apb
    // One read command: write, drain bytes and results, check events
    task automatic run_cmd(input logic [7:0] opc);
        logic [7:0] b [9];
        logic del;
        int q [$];
        int k = 0;
        b[0] = opc;
        b[1] = {5'h0, 3'(rnd())};
        for (int i = 2; i < 9; i++) b[i] = rnd();
        del = (opc[4:0] == OP_LOW_DEL);
        for (int i = 0; i < 9; i++) begin
            do begin
                apb(1'b0, ADDR_MSR, 8'h00);
                k++;
            end while (rdv[7:6] !== 2'b10 && k < LIM);
            bound(k);
            apb(1'b1, ADDR_DATA, b[i]);
        end
        for (int i = 0; i < NSEC; i++) if (!(opc[OP_SK_BIT] && i[0] != del)) q.push_back(8'hA0 + i);
        q = {q, b[1], 0, 0, b[2], b[3], 8'(b[4] + NSEC), b[5]};
        apb(1'b0, ADDR_PHASE, 8'h00);
        chk(rdv, 32'h2);
        chk(cmdOut, {opc[7:5], del, b[1][2:0], b[2], b[3], b[4], b[5], b[6], b[7], b[8]});
        k = 0;
        while (q.size() > 0 && k < LIM) begin
            apb(1'b0, ADDR_MSR, 8'h00);
            if (rdv[7:6] === 2'b11) begin
                apb(1'b0, ADDR_DATA, 8'h00);
                chk(rdv, q.pop_front());
            end
            k++;
        end
        bound(k);
        apb(1'b0, ADDR_PHASE, 8'h00);
        chk(rdv, 32'h0);
        apb(1'b0, ADDR_ISR, 8'h00);
        chk(rdv, 32'h3);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_IMR, 8'h00);
        apb(1'b0, ADDR_MSR, 8'h00);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_IMR, 8'h01);
        apb(1'b1, ADDR_ISR, 8'h07);
        apb(1'b0, ADDR_ISR, 8'h00);
        chk(rdv, 32'h0);
    endtask : run_cmd
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h20, 8'h00);
        chk({errv, rdv}, {1'b1, 32'h0});
        for (int i = 0; i < 3; i++) begin
            op = rnd();
            if (op[4:0] == OP_LOW_READ || op[4:0] == OP_LOW_DEL) op[4] = 1'b1;
            apb(1'b1, ADDR_DATA, op);
            apb(1'b0, ADDR_ISR, 8'h00);
            chk({otherOp, rdv}, {op, 32'h4});
            apb(1'b1, ADDR_ISR, 8'h07);
        end
        apb(1'b1, ADDR_IMR, 8'h01);
        foreach (ops[i]) run_cmd(ops[i]);
        stop_test();
    end
endmodule : drc_read_cmd_test

// File: hdl/drc_byte_mem.sv
// Purpose: Small byte store for the result phase
// Assumes: One port, write and read share the address
// Notes: Read data come out of a register, one cycle after the address

`timescale 1ns/1ps

module drc_byte_mem (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Access port
    input wire logic wrEn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] mem_q [8]; // Eight byte cells
    logic [7:0] rdData_q; // Registered read word

    // Write port, no reset needed on the array
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem_q[addr] <= wrData;
        end
    end

    // Registered read so the bus sees a stable byte
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= mem_q[addr];
        end
    end

    assign rdData = rdData_q;

endmodule : drc_byte_mem

// File: hdl/drc_irq.sv
// Purpose: Sticky event flags, mask and level interrupt
// Assumes: Event pulses and software writes on the same clock
// Notes: A new event wins over a clear in the same cycle

`timescale 1ns/1ps

module drc_irq
    import drc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Events and software access
    input wire logic [EV_W-1:0] evIn,
    input wire logic clrWr,
    input wire logic maskWr,
    input wire logic [EV_W-1:0] wrData,
    // State seen by software and the pin
    output logic [EV_W-1:0] status,
    output logic [EV_W-1:0] mask,
    output logic irq
);

    // ************************************************************
    // State
    // ************************************************************
    logic [EV_W-1:0] status_q, status_d; // Sticky flags
    logic [EV_W-1:0] mask_q, mask_d; // Enable per flag
    logic irq_q, irq_d; // Registered level

    // Next values, set ORed in after the clear
    always_comb begin
        status_d = status_q;
        mask_d = mask_q;
        if (clrWr) begin
            status_d = status_q & ~wrData;
        end
        status_d = status_d | evIn;
        if (maskWr) begin
            mask_d = wrData;
        end
        // Follows the flags in the same cycle
        irq_d = |(status_d & mask_d);
    end

    // Register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_q <= ISR_RESET;
            mask_q <= IMR_RESET;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = irq_q;

endmodule : drc_irq

// File: hdl/drc_pkg.sv
// Purpose: Shared constants and types for the sector-read command block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: All offsets, counts and interrupt reset values live here; drive select bits 1 and 0 are fixed in drc_read_cmd

package drc_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_MSR = 8'h00; // Main status, read only
    localparam logic [7:0] ADDR_DATA = 8'h04; // Command in, data and result out
    localparam logic [7:0] ADDR_ISR = 8'h08; // Sticky events, write one to clear
    localparam logic [7:0] ADDR_IMR = 8'h0C; // Event mask, same layout
    localparam logic [7:0] ADDR_PHASE = 8'h10; // Current phase code, read only

    // ************************************************************
    // Main status bit positions
    // ************************************************************
    localparam int MSR_RQM_BIT = 7; // Request for master
    localparam int MSR_DIO_BIT = 6; // Direction: 1 means controller to host
    localparam int MSR_EXEC_BIT = 5; // Execution phase in progress
    localparam int MSR_BUSY_BIT = 4; // Command in progress

    // ************************************************************
    // Opcode layout
    // ************************************************************
    localparam int OP_MT_BIT = 7; // Multi-track flag
    localparam int OP_DD_BIT = 6; // Double-density flag
    localparam int OP_SK_BIT = 5; // Skip mismatched mark flag
    localparam logic [4:0] OP_LOW_READ = 5'h06; // Normal sector read
    localparam logic [4:0] OP_LOW_DEL = 5'h0C; // Deleted-data read
    localparam int SEL_HEAD_BIT = 2; // Head select in second byte

    // ************************************************************
    // Phase lengths
    // ************************************************************
    localparam logic [3:0] CMD_BYTES = 4'h9; // Opcode plus eight parameters
    localparam logic [3:0] RES_BYTES = 4'h7; // Three status bytes plus C H R N

    // ************************************************************
    // Interrupt events
    // ************************************************************
    localparam int EV_RESULT = 0; // Result phase entered
    localparam int EV_BYTE = 1; // Sector byte waiting for the host
    localparam int EV_FOREIGN = 2; // Opcode handed to the general decoder
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] ISR_RESET = 3'h0;
    localparam logic [EV_W-1:0] IMR_RESET = 3'h0;

    // Phases of one command
    typedef enum {PH_IDLE, PH_CMD, PH_EXEC, PH_LOAD, PH_RES} drc_phase_t;

    // Decoded command handed to the drive engine
    typedef struct packed {
        logic multiTrackFlag;
        logic doubleDensityFlag;
        logic skipMismatchedMarkFlag;
        logic deletedRead;
        logic headSelectBit;
        logic driveSelectHigh;
        logic driveSelectLow;
        logic [7:0] cylinder;
        logic [7:0] head;
        logic [7:0] record;
        logic [7:0] sizeCode;
        logic [7:0] lastSectorOnTrack;
        logic [7:0] gapLengthByte;
        logic [7:0] dataLengthByte;
    } drc_cmd_t;

    // One sector byte from the drive engine
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic deletedMark;
    } drc_sec_t;

    // End of execution with its result bytes
    typedef struct packed {
        logic valid;
        logic [7:0] resultStatusZero;
        logic [7:0] resultStatusOne;
        logic [7:0] resultStatusTwo;
        logic [7:0] cylinder;
        logic [7:0] head;
        logic [7:0] record;
        logic [7:0] sizeCode;
    } drc_end_t;

endpackage : drc_pkg

// File: hdl/drc_read_cmd.sv
// Purpose: Command decode and phase sequencing for the two sector reads
// Assumes: Drive engine and general decoder run on ref_clk
// Notes: Registers over APB; one byte holding stage toward the host
//
// Functional notes
// - Opcode bits 7..5 flags; low five select read
// - Execution moves sector bytes; results wait
// - Result: three status bytes, then sector ID
// - Skip flag drops sectors with mismatched mark
// - Phases run command, execution, result in order
//
// The address map and the APB register port are this design's own decisions.

`timescale 1ns/1ps

module drc_read_cmd
    import drc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive engine
    input wire drc_sec_t secIn,
    input wire drc_end_t endIn,
    output logic drvReady,
    output logic startRead,
    output drc_cmd_t cmdOut,
    // General command decoder
    output logic otherOpValid,
    output logic [7:0] otherOp,
    // Interrupt
    output logic irq
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic access; // Access phase, first or later cycle
    logic wrDone; // Write takes effect this edge
    logic rdDone; // Read completes this edge
    logic mapped; // Address hits a register
    logic [7:0] wrByte; // Low byte of write data

    assign access = psel & penable;
    assign wrDone = access & pready & pwrite;
    assign rdDone = access & pready & ~pwrite;
    assign wrByte = pwdata[7:0];
    assign mapped = (paddr == ADDR_MSR) || (paddr == ADDR_DATA) || (paddr == ADDR_ISR)
                    || (paddr == ADDR_IMR) || (paddr == ADDR_PHASE);

    // ************************************************************
    // State
    // ************************************************************
    drc_phase_t phase_q, phase_d; // Command phase
    logic [3:0] cnt_q, cnt_d; // Byte index within a phase
    drc_cmd_t cmd_q, cmd_d; // Captured command
    drc_end_t end_q, end_d; // Latched completion
    logic endSeen_q, endSeen_d; // Drive engine has finished
    logic [7:0] hold_q, hold_d; // Sector byte for the host
    logic holdFull_q, holdFull_d; // Holding stage occupied
    logic drvReady_q, drvReady_d; // Drive may hand a byte
    logic startRead_q, startRead_d; // One-cycle start pulse
    logic otherOpValid_q, otherOpValid_d; // One-cycle hand-off pulse
    logic [7:0] otherOp_q, otherOp_d; // Opcode handed off
    logic [31:0] prdata_q, prdata_d; // Bus read word
    logic pready_q, pready_d; // Bus answer
    logic pslverr_q, pslverr_d; // Unmapped address answer
    logic [EV_W-1:0] ev; // Event pulses this cycle
    logic memWr; // Result byte store write
    logic [7:0] memWrData; // Result byte being stored
    logic [7:0] memRd; // Result byte at cnt_q
    logic [EV_W-1:0] isr; // Sticky flags
    logic [EV_W-1:0] imr; // Mask
    logic [7:0] msr; // Main status byte

    // ************************************************************
    // Main status byte
    // ************************************************************
    always_comb begin
        msr = 8'h00;
        // Host may write in idle and command, read when a byte waits
        msr[MSR_RQM_BIT] = (phase_q == PH_IDLE) || (phase_q == PH_CMD)
                           || (phase_q == PH_EXEC && holdFull_q)
                           || (phase_q == PH_RES);
        msr[MSR_DIO_BIT] = (phase_q == PH_EXEC) || (phase_q == PH_RES);
        msr[MSR_EXEC_BIT] = (phase_q == PH_EXEC);
        msr[MSR_BUSY_BIT] = (phase_q != PH_IDLE);
    end

    // ************************************************************
    // Result byte store: filled during load, read during result
    // ************************************************************
    always_comb begin
        memWr = (phase_q == PH_LOAD);
        // Fixed order of the seven result bytes
        case (cnt_q)
            4'h0: memWrData = end_q.resultStatusZero;
            4'h1: memWrData = end_q.resultStatusOne;
            4'h2: memWrData = end_q.resultStatusTwo;
            4'h3: memWrData = end_q.cylinder;
            4'h4: memWrData = end_q.head;
            4'h5: memWrData = end_q.record;
            4'h6: memWrData = end_q.sizeCode;
            default: memWrData = 8'h00;
        endcase
    end

    drc_byte_mem u_res_mem (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wrEn(memWr),
        .addr(cnt_q[2:0]),
        .wrData(memWrData),
        .rdData(memRd)
    );

    // ************************************************************
    // Phase sequencing, command capture and data path
    // ************************************************************
    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        end_d = end_q;
        endSeen_d = endSeen_q;
        hold_d = hold_q;
        holdFull_d = holdFull_q;
        startRead_d = 1'b0;
        otherOpValid_d = 1'b0;
        otherOp_d = otherOp_q;
        ev = '0;
        case (phase_q)
            // Waiting for an opcode
            PH_IDLE: begin
                if (wrDone && paddr == ADDR_DATA) begin
                    cmd_d.multiTrackFlag = wrByte[OP_MT_BIT];
                    cmd_d.doubleDensityFlag = wrByte[OP_DD_BIT];
                    cmd_d.skipMismatchedMarkFlag = wrByte[OP_SK_BIT];
                    cmd_d.deletedRead = (wrByte[4:0] == OP_LOW_DEL);
                    if (wrByte[4:0] == OP_LOW_READ || wrByte[4:0] == OP_LOW_DEL) begin
                        phase_d = PH_CMD;
                        cnt_d = 4'h1;
                    end else begin
                        // Not ours: no execution phase is started
                        otherOpValid_d = 1'b1;
                        otherOp_d = wrByte;
                        ev[EV_FOREIGN] = 1'b1;
                    end
                end
            end
            // Collecting the eight parameter bytes in order
            PH_CMD: begin
                if (wrDone && paddr == ADDR_DATA) begin
                    case (cnt_q)
                        4'h1: begin
                            // Upper five bits are the host's duty; ignored here
                            cmd_d.headSelectBit = wrByte[SEL_HEAD_BIT];
                            cmd_d.driveSelectHigh = wrByte[1];
                            cmd_d.driveSelectLow = wrByte[0];
                        end
                        4'h2: cmd_d.cylinder = wrByte;
                        4'h3: cmd_d.head = wrByte;
                        4'h4: cmd_d.record = wrByte;
                        4'h5: cmd_d.sizeCode = wrByte;
                        4'h6: cmd_d.lastSectorOnTrack = wrByte;
                        4'h7: cmd_d.gapLengthByte = wrByte;
                        4'h8: cmd_d.dataLengthByte = wrByte;
                        default: cmd_d = cmd_q;
                    endcase
                    if (cnt_q == CMD_BYTES - 4'h1) begin
                        phase_d = PH_EXEC;
                        cnt_d = 4'h0;
                        startRead_d = 1'b1;
                        endSeen_d = 1'b0;
                        holdFull_d = 1'b0; // Stale data never reach the host
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            // Moving sector bytes from the drive to the host
            PH_EXEC: begin
                if (rdDone && paddr == ADDR_DATA) begin
                    holdFull_d = 1'b0;
                end
                if (secIn.valid && drvReady_q) begin
                    // Mismatched mark with skip set: byte is consumed, not shown
                    if (!(cmd_q.skipMismatchedMarkFlag
                          && (secIn.deletedMark != cmd_q.deletedRead))) begin
                        hold_d = secIn.data;
                        holdFull_d = 1'b1;
                        ev[EV_BYTE] = 1'b1;
                    end
                end
                if (endIn.valid && !endSeen_q) begin
                    end_d = endIn;
                    endSeen_d = 1'b1;
                end
                // Results only after the host has drained the last byte
                if (endSeen_q && !holdFull_q) begin
                    phase_d = PH_LOAD;
                    cnt_d = 4'h0;
                end
            end
            // Writing the seven result bytes into the store
            PH_LOAD: begin
                if (cnt_q == RES_BYTES - 4'h1) begin
                    phase_d = PH_RES;
                    cnt_d = 4'h0;
                    ev[EV_RESULT] = 1'b1;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            // Host reads the result bytes one per data read
            PH_RES: begin
                if (rdDone && paddr == ADDR_DATA) begin
                    if (cnt_q == RES_BYTES - 4'h1) begin
                        phase_d = PH_IDLE;
                        cnt_d = 4'h0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            default: begin
                phase_d = PH_IDLE;
                cnt_d = 4'h0;
            end
        endcase
        // Drive may offer a byte only while the stage is free
        drvReady_d = (phase_d == PH_EXEC) && !holdFull_d && !endSeen_d;
    end

    // ************************************************************
    // Bus answer: one wait state, read word captured on first access cycle
    // ************************************************************
    always_comb begin
        pready_d = access & ~pready_q;
        pslverr_d = access & ~pready_q & ~mapped;
        prdata_d = prdata_q;
        if (access && !pready_q) begin
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    ADDR_MSR: prdata_d[7:0] = msr;
                    ADDR_DATA: begin
                        if (phase_q == PH_RES) begin
                            prdata_d[7:0] = memRd;
                        end else if (phase_q == PH_EXEC && holdFull_q) begin
                            prdata_d[7:0] = hold_q;
                        end else begin
                            prdata_d[7:0] = 8'h00;
                        end
                    end
                    ADDR_ISR: prdata_d[EV_W-1:0] = isr;
                    ADDR_IMR: prdata_d[EV_W-1:0] = imr;
                    ADDR_PHASE: prdata_d[2:0] = 3'(phase_q);
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_q <= PH_IDLE;
            cnt_q <= 4'h0;
            cmd_q <= '0;
            end_q <= '0;
            endSeen_q <= 1'b0;
            hold_q <= 8'h00;
            holdFull_q <= 1'b0;
            drvReady_q <= 1'b0;
            startRead_q <= 1'b0;
            otherOpValid_q <= 1'b0;
            otherOp_q <= 8'h00;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            end_q <= end_d;
            endSeen_q <= endSeen_d;
            hold_q <= hold_d;
            holdFull_q <= holdFull_d;
            drvReady_q <= drvReady_d;
            startRead_q <= startRead_d;
            otherOpValid_q <= otherOpValid_d;
            otherOp_q <= otherOp_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ************************************************************
    // Interrupt flags
    // ************************************************************
    drc_irq u_irq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .evIn(ev),
        .clrWr(wrDone && paddr == ADDR_ISR),
        .maskWr(wrDone && paddr == ADDR_IMR),
        .wrData(pwdata[EV_W-1:0]),
        .status(isr),
        .mask(imr),
        .irq(irq)
    );

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign drvReady = drvReady_q;
    assign startRead = startRead_q;
    assign cmdOut = cmd_q;
    assign otherOpValid = otherOpValid_q;
    assign otherOp = otherOp_q;

endmodule : drc_read_cmd
